// ---- tcc_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_cpu_model (
	input  wire logic       clock,
	output var  logic [2:0] cpu_addr,
	output var  logic       cpu_write,
	output var  logic       cpu_read,
	output var  logic [7:0] cpu_wdata,
	input  wire logic [7:0] cpu_rdata,
	output var  logic       overflow_irq_ack,
	output var  logic       capture_irq_ack
);
	initial begin
		{cpu_addr, cpu_write, cpu_read, cpu_wdata} = 13'h0000;
		{overflow_irq_ack, capture_irq_ack} = 2'h0;
	end
	// Byte cycles, strobe held over one rising edge
	task automatic wr(input logic [2:0] addr, input logic [7:0] data);
		@(negedge clock);
		{cpu_addr, cpu_wdata, cpu_write} = {addr, data, 1'b1};
		@(negedge clock);
		{cpu_addr, cpu_wdata, cpu_write} = {~addr, ~data, 1'b0};
	endtask : wr
	task automatic rd(input logic [2:0] addr, output logic [7:0] data);
		@(negedge clock);
		{cpu_addr, cpu_read} = {addr, 1'b1};
		@(negedge clock);
		{cpu_addr, cpu_read} = {~addr, 1'b0};
		data = cpu_rdata;
	endtask : rd
	task automatic wr16(input logic [2:0] lo, input logic [15:0] value);
		wr(3'(lo + 3'h1), value[15:8]);
		wr(lo, value[7:0]);
	endtask : wr16
	task automatic rd16(input logic [2:0] lo, output logic [15:0] value);
		rd(lo, value[7:0]);
		rd(3'(lo + 3'h1), value[15:8]);
	endtask : rd16
	task automatic ack(input logic cap);
		@(negedge clock);
		{capture_irq_ack, overflow_irq_ack} = {cap, !cap};
		@(negedge clock);
		{capture_irq_ack, overflow_irq_ack} = 2'h0;
	endtask : ack
endmodule : tcc_cpu_model
`default_nettype wire

// ---- tcc_edge_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tcc_edge_if;
	logic level;
	logic rise;
	logic fall;
	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface : tcc_edge_if
`default_nettype wire

// ---- tcc_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_edge_sync (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       raw_in,
	tcc_edge_if.producer    edges
);

	// ---------------------------------------------------------------
	// Three-stage synchroniser
	// ---------------------------------------------------------------
	logic sync_1;
	logic sync_2;
	logic sync_3;
	logic stable;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_1 <= 1'b0;
			sync_2 <= 1'b0;
			sync_3 <= 1'b0;
		end else begin
			sync_1 <= raw_in;
			sync_2 <= sync_1;
			sync_3 <= sync_2;
		end
	end

	// ---------------------------------------------------------------
	// Accepted level and edges
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stable <= 1'b0;
		end else if (sync_2 == sync_3) begin
			stable <= sync_3;
		end
	end

	assign edges.level = stable;
	assign edges.rise  = sync_2 & sync_3 & ~stable;
	assign edges.fall  = ~sync_2 & ~sync_3 & stable;

endmodule : tcc_edge_sync
`default_nettype wire

// ---- tcc_pkg.sv ----
package tcc_pkg;

	// ---------------------------------------------------------------
	// Bus
	// ---------------------------------------------------------------
	localparam int          ADDR_W            = 3;
	localparam logic [2:0]  ADDR_CONTROL_A    = 3'h0;
	localparam logic [2:0]  ADDR_CONTROL_B    = 3'h1;
	localparam logic [2:0]  ADDR_COUNTER_LOW  = 3'h2;
	localparam logic [2:0]  ADDR_COUNTER_HIGH = 3'h3;
	localparam logic [2:0]  ADDR_CAPTURE_LOW  = 3'h4;
	localparam logic [2:0]  ADDR_CAPTURE_HIGH = 3'h5;
	localparam logic [2:0]  ADDR_IRQ_MASK     = 3'h6;
	localparam logic [2:0]  ADDR_FLAGS        = 3'h7;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int          CTRL_A_WGM_LSB    = 0;
	localparam int          CTRL_B_CS_LSB     = 0;
	localparam int          CTRL_B_WGM_LSB    = 3;
	localparam int          CTRL_B_EDGE_BIT   = 6;
	localparam int          OVF_BIT           = 0;
	localparam int          CAP_BIT           = 5;

	// ---------------------------------------------------------------
	// Reset values and write masks
	// ---------------------------------------------------------------
	localparam logic [7:0]  BYTE_RESET        = 8'h00;
	localparam logic [15:0] WORD_RESET        = 16'h0000;
	localparam logic [7:0]  CONTROL_A_MASK    = 8'h03;
	localparam logic [7:0]  CONTROL_B_MASK    = 8'h5F;
	localparam logic [7:0]  FLAG_MASK         = 8'h21;

	// ---------------------------------------------------------------
	// Count limits
	// ---------------------------------------------------------------
	localparam logic [15:0] COUNT_SEQUENCE_A      = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT          = 16'h00FF;
	localparam logic [15:0] TOP_9BIT          = 16'h01FF;
	localparam logic [15:0] TOP_10BIT         = 16'h03FF;
	localparam logic [15:0] COUNT_STEP        = 16'h0001;

	// ---------------------------------------------------------------
	// Clock select codes and prescale masks
	// ---------------------------------------------------------------
	localparam logic [2:0]  CS_STOP           = 3'h0;
	localparam logic [2:0]  CS_DIV1           = 3'h1;
	localparam logic [2:0]  CS_DIV8           = 3'h2;
	localparam logic [2:0]  CS_DIV64          = 3'h3;
	localparam logic [2:0]  CS_DIV256         = 3'h4;
	localparam logic [2:0]  CS_DIV1024        = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL       = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE       = 3'h7;
	localparam int          PRESCALE_W        = 10;
	localparam logic [9:0]  PRESCALE_STEP     = 10'h001;
	localparam logic [9:0]  MASK_DIV8         = 10'h007;
	localparam logic [9:0]  MASK_DIV64        = 10'h03F;
	localparam logic [9:0]  MASK_DIV256       = 10'h0FF;
	localparam logic [9:0]  MASK_DIV1024      = 10'h3FF;

endpackage : tcc_pkg

// ---- tcc_timer16.sv ----
// Function
// R1: Counter low read loads holding register
// R2: Counter low write loads all sixteen bits
// R3: High-byte accesses reach holding register only
// R4: Holding byte may serve several writes
// R5: Each step moves counter by one
// R6: Clear request zeroes every counter bit
// R7: Sequence_a at zero, top at sequence top
// R8: Clock select zero stops the counter
// R9: Counter accessible with or without clock
// R10: Processor write beats clear and count
// R11: Each tick clears, increments or decrements
// R12: Four-bit mode sets top and direction
// R13: Overflow flag per mode, raises interrupt
// R14: Capture on chosen edge of source
// R15: Capture copies full sixteen-bit count
// R16: Capture flag set with the copy
// R17: Enabled capture flag raises interrupt
// R18: Interrupt execution clears capture flag
// R19: Writing one clears capture flag
// R20: Capture low read loads holding register
// R21: Capture writes only in capture-top modes
// R22: Comparator trigger only in first instance
// R23: Processor writes high byte first
// R24: One holding register shared by all
// R25: Counter maximum is all ones
// R26: Reset clears everything, timer stopped
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16 #(
	parameter bit HAS_COMPARATOR = 1'b1
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [2:0] cpu_addr,
	input  wire logic       cpu_write,
	input  wire logic       cpu_read,
	input  wire logic [7:0] cpu_wdata,
	output var  logic [7:0] cpu_rdata,
	input  wire logic       capture_input_pin,
	input  wire logic       comparator_output,
	input  wire logic       capture_from_comparator,
	input  wire logic       timer_clock_pin,
	input  wire logic       overflow_irq_ack,
	input  wire logic       capture_irq_ack,
	output logic            overflow_irq,
	output logic            capture_irq,
	output logic            sequence_a,
	output logic            count_at_top
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]  timer_control_a;
	logic [7:0]  timer_control_b;
	logic [7:0]  irq_mask;
	logic [7:0]  holding;
	logic [15:0] count_value;
	logic [15:0] capture_value;
	logic        overflow_flag;
	logic        capture_flag;
	logic        count_down;
	logic [9:0]  prescale_count;

	logic [3:0]  waveform_mode;
	logic [2:0]  clock_select;
	logic        capture_edge_rising;
	logic        capture_irq_enable;
	logic        overflow_irq_enable;
	logic [15:0] top_value;
	logic        dual_slope;
	logic        fast_pwm;
	logic        capture_is_top;
	logic        timer_tick;
	logic        overflow_event;
	logic        capture_event;
	logic        use_comparator;
	logic [15:0] next_count;

	tcc_edge_if pin_edges ();
	tcc_edge_if cmp_edges ();
	tcc_edge_if ext_edges ();

	tcc_edge_sync u_pin_sync (
		.clock  (clock),
		.rst_n  (rst_n),
		.raw_in (capture_input_pin),
		.edges  (pin_edges)
	);

	tcc_edge_sync u_cmp_sync (
		.clock  (clock),
		.rst_n  (rst_n),
		.raw_in (comparator_output),
		.edges  (cmp_edges)
	);

	tcc_edge_sync u_ext_sync (
		.clock  (clock),
		.rst_n  (rst_n),
		.raw_in (timer_clock_pin),
		.edges  (ext_edges)
	);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic wr_ctrl_a;
	logic wr_ctrl_b;
	logic wr_cnt_lo;
	logic wr_cap_lo;
	logic wr_high;
	logic wr_mask;
	logic wr_flags;
	logic rd_cnt_lo;
	logic rd_cap_lo;

	assign wr_ctrl_a = cpu_write && (cpu_addr == tcc_pkg::ADDR_CONTROL_A);
	assign wr_ctrl_b = cpu_write && (cpu_addr == tcc_pkg::ADDR_CONTROL_B);
	assign wr_cnt_lo = cpu_write && (cpu_addr == tcc_pkg::ADDR_COUNTER_LOW);
	assign wr_cap_lo = cpu_write && (cpu_addr == tcc_pkg::ADDR_CAPTURE_LOW);
	assign wr_high   = cpu_write && ((cpu_addr == tcc_pkg::ADDR_COUNTER_HIGH) ||
	                   (cpu_addr == tcc_pkg::ADDR_CAPTURE_HIGH));
	assign wr_mask   = cpu_write && (cpu_addr == tcc_pkg::ADDR_IRQ_MASK);
	assign wr_flags  = cpu_write && (cpu_addr == tcc_pkg::ADDR_FLAGS);
	assign rd_cnt_lo = cpu_read && (cpu_addr == tcc_pkg::ADDR_COUNTER_LOW);
	assign rd_cap_lo = cpu_read && (cpu_addr == tcc_pkg::ADDR_CAPTURE_LOW);

	assign waveform_mode = {timer_control_b[tcc_pkg::CTRL_B_WGM_LSB +: 2],
	                        timer_control_a[tcc_pkg::CTRL_A_WGM_LSB +: 2]}; // [R12]
	assign clock_select        = timer_control_b[tcc_pkg::CTRL_B_CS_LSB +: 3];
	assign capture_edge_rising = timer_control_b[tcc_pkg::CTRL_B_EDGE_BIT];
	assign capture_irq_enable  = irq_mask[tcc_pkg::CAP_BIT];
	assign overflow_irq_enable = irq_mask[tcc_pkg::OVF_BIT];

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timer_control_a <= tcc_pkg::BYTE_RESET;
			timer_control_b <= tcc_pkg::BYTE_RESET; // [R26]
			irq_mask        <= tcc_pkg::BYTE_RESET;
		end else begin
			if (wr_ctrl_a) begin
				timer_control_a <= cpu_wdata & tcc_pkg::CONTROL_A_MASK;
			end
			if (wr_ctrl_b) begin
				timer_control_b <= cpu_wdata & tcc_pkg::CONTROL_B_MASK;
			end
			if (wr_mask) begin
				irq_mask <= cpu_wdata & tcc_pkg::FLAG_MASK;
			end
		end
	end

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	always_comb begin
		top_value      = tcc_pkg::COUNT_MAX; // [R25]
		dual_slope     = 1'b0;
		fast_pwm       = 1'b0;
		capture_is_top = 1'b0;
		case (waveform_mode) // [R12]
			4'h1: begin
				dual_slope = 1'b1;
				top_value  = tcc_pkg::TOP_8BIT;
			end
			4'h2: begin
				dual_slope = 1'b1;
				top_value  = tcc_pkg::TOP_9BIT;
			end
			4'h3: begin
				dual_slope = 1'b1;
				top_value  = tcc_pkg::TOP_10BIT;
			end
			4'h5: begin
				fast_pwm  = 1'b1;
				top_value = tcc_pkg::TOP_8BIT;
			end
			4'h6: begin
				fast_pwm  = 1'b1;
				top_value = tcc_pkg::TOP_9BIT;
			end
			4'h7: begin
				fast_pwm  = 1'b1;
				top_value = tcc_pkg::TOP_10BIT;
			end
			4'h8, 4'hA: begin
				dual_slope     = 1'b1;
				capture_is_top = 1'b1;
				top_value      = capture_value;
			end
			4'h9, 4'hB: begin
				dual_slope = 1'b1;
			end
			4'hC: begin
				capture_is_top = 1'b1;
				top_value      = capture_value;
			end
			4'hE: begin
				fast_pwm       = 1'b1;
				capture_is_top = 1'b1;
				top_value      = capture_value;
			end
			4'hF: begin
				fast_pwm = 1'b1;
			end
			default: begin
				top_value = tcc_pkg::COUNT_MAX;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Timer clock
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prescale_count <= '0;
		end else begin
			prescale_count <= prescale_count + tcc_pkg::PRESCALE_STEP;
		end
	end

	always_comb begin
		case (clock_select)
			tcc_pkg::CS_STOP:     timer_tick = 1'b0; // [R8]
			tcc_pkg::CS_DIV1:     timer_tick = 1'b1;
			tcc_pkg::CS_DIV8:     timer_tick = &(prescale_count | ~tcc_pkg::MASK_DIV8);
			tcc_pkg::CS_DIV64:    timer_tick = &(prescale_count | ~tcc_pkg::MASK_DIV64);
			tcc_pkg::CS_DIV256:   timer_tick = &(prescale_count | ~tcc_pkg::MASK_DIV256);
			tcc_pkg::CS_DIV1024:  timer_tick = &(prescale_count | ~tcc_pkg::MASK_DIV1024);
			tcc_pkg::CS_EXT_FALL: timer_tick = ext_edges.fall;
			tcc_pkg::CS_EXT_RISE: timer_tick = ext_edges.rise;
			default:              timer_tick = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	always_comb begin
		next_count = count_value;
		if (dual_slope) begin
			if (count_down) begin
				if (count_value == tcc_pkg::COUNT_SEQUENCE_A) begin
					next_count = count_value + tcc_pkg::COUNT_STEP; // [R5]
				end else begin
					next_count = count_value - tcc_pkg::COUNT_STEP;
				end
			end else if (count_value >= top_value) begin
				next_count = count_value - tcc_pkg::COUNT_STEP;
			end else begin
				next_count = count_value + tcc_pkg::COUNT_STEP;
			end
		end else if (count_value >= top_value) begin
			next_count = tcc_pkg::COUNT_SEQUENCE_A; // [R6]
		end else begin
			next_count = count_value + tcc_pkg::COUNT_STEP; // [R5]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_value <= tcc_pkg::WORD_RESET; // [R26]
		end else if (wr_cnt_lo) begin
			count_value <= {holding, cpu_wdata}; // [R2] [R9] [R10] [R23]
		end else if (timer_tick) begin
			count_value <= next_count; // [R11]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_down <= 1'b0;
		end else if (!dual_slope) begin
			count_down <= 1'b0;
		end else if (timer_tick && !wr_cnt_lo) begin
			if (count_down && (count_value == tcc_pkg::COUNT_SEQUENCE_A)) begin
				count_down <= 1'b0;
			end else if (!count_down && (count_value >= top_value)) begin
				count_down <= 1'b1;
			end
		end
	end

	assign sequence_a   = (count_value == tcc_pkg::COUNT_SEQUENCE_A); // [R7]
	assign count_at_top = (count_value == top_value);

	// ---------------------------------------------------------------
	// Overflow
	// ---------------------------------------------------------------
	always_comb begin
		if (!timer_tick || wr_cnt_lo) begin
			overflow_event = 1'b0;
		end else if (dual_slope) begin
			overflow_event = count_down && (count_value == tcc_pkg::COUNT_SEQUENCE_A);
		end else if (fast_pwm) begin
			overflow_event = (count_value >= top_value);
		end else begin
			overflow_event = (count_value == tcc_pkg::COUNT_MAX);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
		end else if (overflow_event) begin
			overflow_flag <= 1'b1; // [R13]
		end else if (overflow_irq_ack || (wr_flags && cpu_wdata[tcc_pkg::OVF_BIT])) begin
			overflow_flag <= 1'b0;
		end
	end

	assign overflow_irq = overflow_flag & overflow_irq_enable; // [R13]

	// ---------------------------------------------------------------
	// Capture
	// ---------------------------------------------------------------
	assign use_comparator = HAS_COMPARATOR && capture_from_comparator; // [R22]

	always_comb begin
		capture_event = 1'b0;
		if (!capture_is_top) begin
			if (use_comparator) begin
				capture_event = capture_edge_rising ? cmp_edges.rise : cmp_edges.fall;
			end else begin
				capture_event = capture_edge_rising ? pin_edges.rise : pin_edges.fall; // [R14]
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			capture_value <= tcc_pkg::WORD_RESET;
		end else if (wr_cap_lo && capture_is_top) begin
			capture_value <= {holding, cpu_wdata}; // [R21]
		end else if (capture_event) begin
			capture_value <= count_value; // [R15]
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			capture_flag <= 1'b0;
		end else if (capture_event) begin
			capture_flag <= 1'b1; // [R16]
		end else if (capture_irq_ack) begin
			capture_flag <= 1'b0; // [R18]
		end else if (wr_flags && cpu_wdata[tcc_pkg::CAP_BIT]) begin
			capture_flag <= 1'b0; // [R19]
		end
	end

	assign capture_irq = capture_flag & capture_irq_enable; // [R17]

	// ---------------------------------------------------------------
	// Shared holding byte
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			holding <= tcc_pkg::BYTE_RESET;
		end else if (wr_high) begin
			holding <= cpu_wdata; // [R3] [R4] [R24]
		end else if (rd_cnt_lo) begin
			holding <= count_value[15:8]; // [R1]
		end else if (rd_cap_lo) begin
			holding <= capture_value[15:8]; // [R20]
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_rdata <= tcc_pkg::BYTE_RESET;
		end else if (cpu_read) begin
			case (cpu_addr)
				tcc_pkg::ADDR_CONTROL_A:    cpu_rdata <= timer_control_a;
				tcc_pkg::ADDR_CONTROL_B:    cpu_rdata <= timer_control_b;
				tcc_pkg::ADDR_COUNTER_LOW:  cpu_rdata <= count_value[7:0]; // [R9]
				tcc_pkg::ADDR_COUNTER_HIGH: cpu_rdata <= holding; // [R3]
				tcc_pkg::ADDR_CAPTURE_LOW:  cpu_rdata <= capture_value[7:0];
				tcc_pkg::ADDR_CAPTURE_HIGH: cpu_rdata <= holding; // [R20]
				tcc_pkg::ADDR_IRQ_MASK:     cpu_rdata <= irq_mask;
				tcc_pkg::ADDR_FLAGS:        cpu_rdata <= {2'b00, capture_flag, 4'h0,
				                                          overflow_flag};
				default:                    cpu_rdata <= tcc_pkg::BYTE_RESET;
			endcase
		end
	end

endmodule : tcc_timer16
`default_nettype wire

// ---- tcc_timer16_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcc_timer16_properties #(
	parameter bit HAS_COMPARATOR = 1'b1
) (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [2:0] cpu_addr,
	input  wire logic       cpu_write,
	input  wire logic       cpu_read,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic [7:0] cpu_rdata,
	input  wire logic       capture_input_pin,
	input  wire logic       comparator_output,
	input  wire logic       capture_from_comparator,
	input  wire logic       timer_clock_pin,
	input  wire logic       overflow_irq_ack,
	input  wire logic       capture_irq_ack,
	input  wire logic       overflow_irq,
	input  wire logic       capture_irq,
	input  wire logic       sequence_a,
	input  wire logic       count_at_top
);
	logic [2:0] quiet;
	logic       flags_wr;
	logic       mask_wr;
	assign flags_wr = cpu_write && (cpu_addr == tcc_pkg::ADDR_FLAGS);
	assign mask_wr  = cpu_write && (cpu_addr == tcc_pkg::ADDR_IRQ_MASK);
	// Cycles since any capture source last moved
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			quiet <= 3'h0;
		else if ($changed({capture_input_pin, comparator_output, capture_from_comparator}))
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_rdata_holds: assert property (!cpu_read |=> $stable(cpu_rdata))
		else $error("read data moved unread");
	chk_cap_ack_clear: assert property (capture_irq_ack && quiet >= 3'h5 |=> !capture_irq)
		else $error("capture kept after ack");
	chk_cap_one_clear: assert property (
		flags_wr && cpu_wdata[tcc_pkg::CAP_BIT] && quiet >= 3'h5 |=> !capture_irq)
		else $error("capture kept after write one");
	chk_cap_zero_keep: assert property (flags_wr && !cpu_wdata[tcc_pkg::CAP_BIT]
		&& capture_irq && !capture_irq_ack |=> capture_irq)
		else $error("capture request lost on write zero");
	chk_write_wins: assert property (cpu_write && cpu_addr == tcc_pkg::ADDR_COUNTER_LOW
		&& cpu_wdata != 8'h00 |=> !sequence_a)
		else $error("counter write lost");
	chk_cap_sticky: assert property (capture_irq && !capture_irq_ack && !flags_wr && !mask_wr
		|=> capture_irq)
		else $error("capture request dropped");
	chk_ovf_sticky: assert property (overflow_irq && !overflow_irq_ack && !flags_wr && !mask_wr
		|=> overflow_irq)
		else $error("overflow request dropped");
	chk_flags_reserved: assert property (cpu_read && cpu_addr == tcc_pkg::ADDR_FLAGS
		|=> (cpu_rdata & ~tcc_pkg::FLAG_MASK) == 8'h00)
		else $error("unused flag bits read as one");
	chk_cap_masked: assert property (mask_wr && !cpu_wdata[tcc_pkg::CAP_BIT] |=> !capture_irq)
		else $error("masked capture request raised");
	chk_ovf_masked: assert property (mask_wr && !cpu_wdata[tcc_pkg::OVF_BIT] |=> !overflow_irq)
		else $error("masked overflow request raised");
	cov_cap_ack: cover property (capture_irq ##1 capture_irq_ack);
	cov_ovf_irq: cover property (overflow_irq && overflow_irq_ack);
	cov_cnt_top: cover property (count_at_top && !sequence_a);
endmodule : tcc_timer16_properties
bind tcc_timer16 tcc_timer16_properties #(.HAS_COMPARATOR(HAS_COMPARATOR)) u_props (
	.clock(clock), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
	.cpu_read(cpu_read), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
	.capture_input_pin(capture_input_pin), .comparator_output(comparator_output),
	.capture_from_comparator(capture_from_comparator), .timer_clock_pin(timer_clock_pin),
	.overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
	.overflow_irq(overflow_irq), .capture_irq(capture_irq), .sequence_a(sequence_a),
	.count_at_top(count_at_top));
`default_nettype wire

// ---- tcc_timer16_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) cmp(16'(g), 16'(e))
module tcc_timer16_tb;
	logic        clock, rst_n, cpu_write, cpu_read, sequence_a, count_at_top;
	logic        capture_input_pin, comparator_output, capture_from_comparator, timer_clock_pin;
	logic        overflow_irq_ack, capture_irq_ack, overflow_irq, capture_irq, rise;
	logic [2:0]  cpu_addr;
	logic [7:0]  cpu_wdata, cpu_rdata, r;
	logic [15:0] seed = 16'hECDE;
	logic [15:0] a, b, v;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;
	tcc_timer16 DUT (.clock(clock), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
		.cpu_read(cpu_read), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.capture_input_pin(capture_input_pin), .comparator_output(comparator_output),
		.capture_from_comparator(capture_from_comparator), .timer_clock_pin(timer_clock_pin),
		.overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack),
		.overflow_irq(overflow_irq), .capture_irq(capture_irq), .sequence_a(sequence_a),
		.count_at_top(count_at_top));
	tcc_cpu_model cpu (.clock(clock), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
		.cpu_read(cpu_read), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.overflow_irq_ack(overflow_irq_ack), .capture_irq_ack(capture_irq_ack));
	function automatic logic [15:0] lfsr();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : lfsr
	function automatic logic [15:0] top_of(input int m);
		return (m == 0) ? 16'hFFFF : 16'((1 << (m + 7)) - 1);
	endfunction : top_of
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic set_src(input logic lvl);
		if (capture_from_comparator) comparator_output = lvl;
		else capture_input_pin = lvl;
		repeat (6) @(negedge clock);
	endtask : set_src
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		{rst_n, capture_input_pin, comparator_output, capture_from_comparator, timer_clock_pin} = 5'h00;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, v);
		`CHK(v, 16'h0000);
		cpu.rd16(tcc_pkg::ADDR_CAPTURE_LOW, v);
		`CHK(v, 16'h0000);
		cpu.rd(tcc_pkg::ADDR_FLAGS, r);
		`CHK(r, 8'h00);
		`CHK({sequence_a, count_at_top}, 2'b10);
		for (int i = 0; i < 8; i++) begin
			v = lfsr();
			cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, v);
			cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
			`CHK(a, v);
		end
		cpu.wr(tcc_pkg::ADDR_COUNTER_HIGH, 8'h5A);
		cpu.rd(tcc_pkg::ADDR_COUNTER_HIGH, r);
		`CHK(r, 8'h5A);
		cpu.wr(tcc_pkg::ADDR_COUNTER_LOW, 8'h11);
		cpu.wr(tcc_pkg::ADDR_COUNTER_LOW, 8'h22);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		`CHK(a, 16'h5A22);
		cpu.rd(tcc_pkg::ADDR_CAPTURE_LOW, r);
		cpu.rd(tcc_pkg::ADDR_COUNTER_HIGH, r);
		`CHK(r, 8'h00);
		cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'h1000);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'(tcc_pkg::CS_DIV1));
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, b);
		`CHK(b - a, 16'h0004);
		cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'hFFFF);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		`CHK(a, 16'h0000);
		cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h21);
		`CHK(overflow_irq, 1'b1);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
		cpu.ack(1'b0);
		`CHK(overflow_irq, 1'b0);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		repeat (5) @(negedge clock);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, b);
		`CHK(b, a);
		for (int m = 0; m < 4; m++) begin
			cpu.wr(tcc_pkg::ADDR_CONTROL_A, 8'(m));
			cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, top_of(m));
			`CHK({sequence_a, count_at_top}, 2'b01);
			cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'h0000);
			`CHK({sequence_a, count_at_top}, 2'b10);
		end
		cpu.wr(tcc_pkg::ADDR_CONTROL_A, 8'h01);
		cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'h00F0);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'(tcc_pkg::CS_DIV1));
		repeat (40) @(negedge clock);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, b);
		`CHK(a - b, 16'h0004);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'h18);
		cpu.wr(tcc_pkg::ADDR_CONTROL_A, 8'h00);
		cpu.wr16(tcc_pkg::ADDR_CAPTURE_LOW, 16'h0010);
		cpu.rd16(tcc_pkg::ADDR_CAPTURE_LOW, a);
		`CHK(a, 16'h0010);
		cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'h0010);
		`CHK(count_at_top, 1'b1);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'h19);
		repeat (7) @(negedge clock);
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		`CHK(a <= 16'h0010, 1'b1);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'h00);
		cpu.wr16(tcc_pkg::ADDR_CAPTURE_LOW, 16'h1234);
		cpu.rd16(tcc_pkg::ADDR_CAPTURE_LOW, a);
		`CHK(a, 16'h0010);
		cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, 16'h0000);
		cpu.wr(tcc_pkg::ADDR_CONTROL_B, 8'(tcc_pkg::CS_EXT_RISE));
		repeat (5) begin
			timer_clock_pin = 1'b1;
			repeat (4) @(negedge clock);
			timer_clock_pin = 1'b0;
			repeat (4) @(negedge clock);
		end
		cpu.rd16(tcc_pkg::ADDR_COUNTER_LOW, a);
		`CHK(a, 16'h0005);
		for (int k = 0; k < 4; k++) begin
			capture_from_comparator = k[0];
			rise = k[1];
			cpu.wr(tcc_pkg::ADDR_CONTROL_B, {1'b0, rise, 6'h00});
			set_src(rise);
			cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
			v = lfsr();
			cpu.wr16(tcc_pkg::ADDR_COUNTER_LOW, v);
			set_src(!rise);
			cpu.rd(tcc_pkg::ADDR_FLAGS, r);
			`CHK(r, 8'h00);
			set_src(rise);
			cpu.rd(tcc_pkg::ADDR_FLAGS, r);
			`CHK(r, 8'h20);
			cpu.rd16(tcc_pkg::ADDR_CAPTURE_LOW, a);
			`CHK(a, v);
		end
		cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h20);
		`CHK(capture_irq, 1'b1);
		cpu.ack(1'b1);
		`CHK(capture_irq, 1'b0);
		set_src(!rise);
		set_src(rise);
		cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h00);
		`CHK(capture_irq, 1'b0);
		cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h20);
		cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h00);
		`CHK(capture_irq, 1'b1);
		cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h21);
		cpu.rd(tcc_pkg::ADDR_FLAGS, r);
		`CHK(r, 8'h00);
		close_out();
	end
endmodule : tcc_timer16_tb
`default_nettype wire
